/* ccd_top.sv */
// ccd_top: clock count and result prescaler of a light sensor front end
// assumes trigger and light pulse pins are asynchronous, temp_code is
// produced on aclk, and an AXI4-Lite master with one access of each kind
`timescale 1ns/1ps
module ccd_top
	import ccd_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low active
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic external_trigger_input, // window pin, async
	input wire logic light_pulse, // photo pulse pin, async
	input wire logic [15:0] temp_code, // temperature sample, aclk domain
	output logic irq // level interrupt
);
	import ccd_pkg::*;

	ccd_state_t s_q;
	ccd_state_t s_d;
	logic tick;
	logic fin;
	logic ovf;
	logic [3:0] shamt;
	logic [23:0] shifted;
	logic [1:0] st_set;
	logic [1:0] st_clr;
	logic [31:0] rd;
	logic rd_ok;
	logic wr_ok;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		st_set = 2'h0;
		st_clr = 2'h0;
		rd = 32'h0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		fin = 1'b0;
		// pin synchronisers
		s_d.trig_s1 = external_trigger_input;
		s_d.trig_s2 = s_q.trig_s1;
		s_d.pul_s1 = light_pulse;
		s_d.pul_s2 = s_q.pul_s1;
		s_d.pul_s3 = s_q.pul_s2;
		// internal measurement clock enable
		tick = (s_q.tick_cnt == TICK_LAST);
		s_d.tick_cnt = tick ? 7'h0 : s_q.tick_cnt + 7'h1;
		// window follows the trigger only in the external mode
		if (!s_q.win && s_q.kind == MODE_EXT && s_q.trig_s2)
		begin
			s_d.win = 1'b1;
			s_d.acc = 24'h0;
			s_d.clk_cnt = 24'h0;
		end
		else if (s_q.win && (!s_q.trig_s2 || s_q.kind != MODE_EXT))
		begin
			s_d.win = 1'b0;
			fin = 1'b1;
		end
		else if (s_q.win)
		begin
			if (s_q.pul_s2 && !s_q.pul_s3 && s_q.acc != 24'hffffff)
				s_d.acc = s_q.acc + 24'h1;
			// clocks counted only with count enable set
			if (s_q.cfg.cnt_en && tick && s_q.clk_cnt != 24'hffffff)
				s_d.clk_cnt = s_q.clk_cnt + 24'h1;
		end
		// prescaler: shift by select plus one only when enabled
		shamt = s_q.cfg.div_en ? {1'b0, s_q.cfg.div_sel} + 4'h1 : 4'h0;
		shifted = s_q.acc >> shamt;
		ovf = (|shifted[23:16]) || s_q.acc == 24'hffffff;
		if (fin)
		begin
			s_d.result = ovf ? 16'hffff : shifted[15:0];
			st_set[STAT_DONE_BIT] = 1'b1;
			st_set[STAT_OVF_BIT] = ovf;
			if (s_q.cfg.cnt_en)
			begin
				s_d.count_res = s_q.clk_cnt;
				s_d.temp_res = temp_code;
				s_d.temp_valid = 1'b1;
			end
			else
				s_d.temp_valid = 1'b0;
		end
		// write channel capture
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		// register write once both halves are in
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			case (s_q.aw_idx)
				REG_CFG_IDX:
				begin
					if (s_q.w_lane0)
					begin
						s_d.cfg.cnt_en = s_q.w_data[CFG_CNT_EN_BIT];
						s_d.cfg.div_en = s_q.w_data[CFG_DIV_EN_BIT];
						s_d.cfg.div_sel = s_q.w_data[CFG_DIV_SEL_LSB +: 3];
					end
				end
				REG_MODE_IDX:
				begin
					if (s_q.w_lane0)
					begin
						s_d.kind = s_q.w_data[MODE_KIND_LSB +: 2];
						s_d.time_code = s_q.w_data[MODE_TIME_LSB +: 4];
					end
				end
				REG_MASK_IDX:
				begin
					if (s_q.w_lane0)
						s_d.mask = s_q.w_data[1:0];
				end
				REG_STATUS_IDX, REG_COUNT_IDX, REG_RESULT_IDX, REG_TEMP_IDX:
					wr_ok = 1'b1;
				default:
					wr_ok = 1'b0;
			endcase
			s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// read decode
		case (s_axi_araddr[7:2])
			REG_CFG_IDX:
			begin
				rd[CFG_CNT_EN_BIT] = s_q.cfg.cnt_en;
				rd[CFG_DIV_EN_BIT] = s_q.cfg.div_en;
				rd[CFG_DIV_SEL_LSB +: 3] = s_q.cfg.div_sel;
			end
			REG_MODE_IDX:
			begin
				rd[MODE_KIND_LSB +: 2] = s_q.kind;
				rd[MODE_TIME_LSB +: 4] = s_q.time_code;
			end
			REG_STATUS_IDX:
				rd[1:0] = s_q.status;
			REG_MASK_IDX:
				rd[1:0] = s_q.mask;
			REG_COUNT_IDX:
				rd[23:0] = s_q.count_res;
			REG_RESULT_IDX:
				rd[15:0] = s_q.result;
			REG_TEMP_IDX:
			begin
				rd[15:0] = s_q.temp_res;
				rd[TEMP_VALID_BIT] = s_q.temp_valid;
			end
			default:
				rd_ok = 1'b0;
		endcase
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd;
			s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr[7:2] == REG_STATUS_IDX)
				st_clr = 2'h3;
		end
		// sticky status, a set in the clearing cycle survives
		s_d.status = (s_q.status & ~st_clr) | st_set;
		s_d.irq = |(s_d.status & s_d.mask);
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.cfg.cnt_en <= CFG_CNT_EN_RST;
			s_q.cfg.div_en <= CFG_DIV_EN_RST;
			s_q.cfg.div_sel <= CFG_DIV_SEL_RST;
			s_q.kind <= MODE_KIND_RST;
			s_q.time_code <= MODE_TIME_RST;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state flops
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign irq = s_q.irq;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [24:0] ratio_chk;
	logic [24:0] quot_chk;
	assign ratio_chk = 25'h2 << s_q.cfg.div_sel;
	// divide as a cross-check of the shift path
	assign quot_chk = 25'(s_q.acc) / ratio_chk;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rst_cfg;
		$rose(aresetn) |-> s_q.cfg.cnt_en && !s_q.cfg.div_en &&
			s_q.cfg.div_sel == 3'h0;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("cfg reset");

	property p_win_mode;
		$rose(s_q.win) |-> $past(s_q.kind) == MODE_EXT && $past(s_q.trig_s2);
	endproperty
	a_win_mode: assert property (p_win_mode) else $error("win start");

	property p_win_end;
		s_q.win && !s_q.trig_s2 |=> !s_q.win && s_q.status[STAT_DONE_BIT];
	endproperty
	a_win_end: assert property (p_win_end) else $error("win end");

	property p_count;
		fin && s_q.cfg.cnt_en |=> s_q.count_res == $past(s_q.clk_cnt) &&
			s_q.temp_valid;
	endproperty
	a_count: assert property (p_count) else $error("count result");

	property p_nocount;
		s_q.win && !s_q.cfg.cnt_en |=> s_q.clk_cnt == $past(s_q.clk_cnt);
	endproperty
	a_nocount: assert property (p_nocount) else $error("counted");

	property p_temp_bad;
		fin && !s_q.cfg.cnt_en |=> !s_q.temp_valid && $stable(s_q.count_res);
	endproperty
	a_temp_bad: assert property (p_temp_bad) else $error("temp valid");

	property p_nodiv;
		fin && !s_q.cfg.div_en && s_q.acc[23:16] == 8'h0 |=>
			24'(s_q.result) == $past(s_q.acc);
	endproperty
	a_nodiv: assert property (p_nodiv) else $error("divided");

	property p_div;
		fin && s_q.cfg.div_en && quot_chk < 25'h10000 |=>
			25'(s_q.result) == $past(quot_chk);
	endproperty
	a_div: assert property (p_div) else $error("divide ratio");

	property p_ovf;
		fin && !s_q.cfg.div_en && s_q.acc[23:16] != 8'h0 |=>
			s_q.status[STAT_OVF_BIT] && s_q.result == 16'hffff;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag");

	property p_rsvd;
		s_axi_arvalid && s_q.arready && s_axi_araddr[7:2] == REG_CFG_IDX |=>
			s_q.rdata[31:7] == 25'h0 && s_q.rdata[5:4] == 2'h0 &&
			s_q.rdata[6] == $past(s_q.cfg.cnt_en);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits");

endmodule

/* ccd_pkg.sv */
// ccd_pkg: constants and types of the conversion count and divider block
// assumes one system clock at 125 MHz and a 32-bit AXI4-Lite register bus
package ccd_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 125000000;
	localparam int unsigned MEAS_CLK_HZ = 1024000;
	localparam int unsigned TICK_CYC = SYS_CLK_HZ / MEAS_CLK_HZ;
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

	// ------------------------------------------------------------
	// register map (word index, byte address is four times it)
	// ------------------------------------------------------------
	localparam logic [5:0] REG_CFG_IDX = 6'h07;
	localparam logic [5:0] REG_MODE_IDX = 6'h10;
	localparam logic [5:0] REG_STATUS_IDX = 6'h11;
	localparam logic [5:0] REG_MASK_IDX = 6'h12;
	localparam logic [5:0] REG_COUNT_IDX = 6'h13;
	localparam logic [5:0] REG_RESULT_IDX = 6'h14;
	localparam logic [5:0] REG_TEMP_IDX = 6'h15;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_CNT_EN_BIT = 6;
	localparam int CFG_DIV_EN_BIT = 3;
	localparam int CFG_DIV_SEL_LSB = 0;
	localparam int MODE_KIND_LSB = 0;
	localparam int MODE_TIME_LSB = 4;
	localparam int TEMP_VALID_BIT = 16;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam logic CFG_CNT_EN_RST = 1'b1;
	localparam logic CFG_DIV_EN_RST = 1'b0;
	localparam logic [2:0] CFG_DIV_SEL_RST = 3'h0;
	localparam logic [1:0] MODE_KIND_RST = 2'h1;
	localparam logic [3:0] MODE_TIME_RST = 4'h6;
	localparam logic [1:0] MODE_EXT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic cnt_en;
		logic div_en;
		logic [2:0] div_sel;
	} ccd_cfg_t;

	typedef struct packed {
		ccd_cfg_t cfg;
		logic [1:0] kind;
		logic [3:0] time_code;
		logic [1:0] status;
		logic [1:0] mask;
		logic irq;
		logic trig_s1;
		logic trig_s2;
		logic pul_s1;
		logic pul_s2;
		logic pul_s3;
		logic [6:0] tick_cnt;
		logic win;
		logic [23:0] clk_cnt;
		logic [23:0] acc;
		logic [23:0] count_res;
		logic [15:0] result;
		logic [15:0] temp_res;
		logic temp_valid;
		logic aw_got;
		logic [5:0] aw_idx;
		logic w_got;
		logic [31:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ccd_state_t;

endpackage

/* ccd_host_model.sv */
// ccd_host_model: host side that frames trigger windows and light pulses
// assumes one aclk domain; go is a one-cycle request from the bench
`timescale 1ns/1ps
module ccd_host_model (
	input wire logic aclk, // system clock
	input wire logic go, // start one window
	input wire logic [15:0] win_cyc, // idle cycles after the pulses
	input wire logic [15:0] n_pulse, // light pulses inside the window
	output logic trig = 1'b0, // drives the trigger pin, low when idle
	output logic pulse = 1'b0, // drives the light pulse pin, low when idle
	output logic busy = 1'b0 // window and settling in progress
);
	int i;
	// ----------------------------------------
	// window generation
	// ----------------------------------------
	// the window length alone bounds the conversion
	always @(posedge aclk)
		if (go && !busy)
		begin
			busy <= 1'b1;
			trig <= 1'b1;
			for (i = 0; i < n_pulse; i++)
			begin
				repeat (4) @(posedge aclk);
				pulse <= 1'b1;
				repeat (4) @(posedge aclk);
				pulse <= 1'b0;
			end
			repeat (win_cyc) @(posedge aclk);
			trig <= 1'b0;
			repeat (8) @(posedge aclk);
			busy <= 1'b0;
		end
endmodule

/* conversion_count_divider_config_test.sv */
// conversion_count_divider_config_test: random and corner register tests
// assumes ccd_top and ccd_host_model; timeout ends a hang
`timescale 1ns/1ps
module conversion_count_divider_config_test;
	import ccd_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic [1:0] bresp, rresp, rs_q, bs_q;
	logic bvalid, awready, wready, arready, rvalid, irq, trig, pulse, busy;
	logic [15:0] temp_code = 16'h0, win_cyc = 16'h0, n_pulse = 16'h0, np;
	logic [7:0] cfg;
	logic [31:0] seed = 32'd45665, cnt_prev;
	int errors = 0, check_count = 0, cyc = 0, k;
	ccd_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_trigger_input(trig),
		.light_pulse(pulse), .temp_code(temp_code), .irq(irq));
	ccd_host_model host (.aclk(aclk), .go(go), .win_cyc(win_cyc),
		.n_pulse(n_pulse), .trig(trig), .pulse(pulse), .busy(busy));
	// ----------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------
	// 125 MHz clock
	always #4 aclk = ~aclk;
	// cut a hang short
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			errors++;
			stop_test();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected light result from count and config
	function automatic logic [31:0] exp_res(input logic [15:0] n,
		input logic [7:0] c);
		logic [31:0] v;
		v = c[3] ? 32'(n) >> (4'(c[2:0]) + 4'h1) : 32'(n);
		return (v > 32'hffff) ? 32'hffff : v;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// bus and window tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				bs_q = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				rd_q = rdata;
				rs_q = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic meas(input logic [15:0] n, input logic [15:0] w);
		@(posedge aclk);
		go <= 1'b1;
		n_pulse <= n;
		win_cyc <= w;
		temp_code <= 16'(xs());
		@(posedge aclk);
		go <= 1'b0;
		do @(posedge aclk); while (busy);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h1c);
		chk(rd_q, 32'h40);
		rd(8'h00);
		chk(32'(rs_q), 32'(RESP_SLVERR));
		wr(8'h00, 32'h0);
		chk(32'(bs_q), 32'(RESP_SLVERR));
		wr(8'h1c, 32'hff);
		chk(32'(bs_q), 32'(RESP_OKAY));
		rd(8'h1c);
		chk(rd_q, 32'h4f);
		wr(8'h48, 32'h1);
		wr(8'h40, 32'h73);
		rd(8'h40);
		chk(rd_q, 32'h73);
		for (k = 0; k < 8; k++)
		begin
			cfg = 8'h40 | (8'(xs()) & 8'h0f);
			if (k == 0)
				cfg = 8'h4f;
			if (k == 1)
				cfg = 8'h47;
			np = 16'(xs() % 300);
			wr(8'h1c, 32'(cfg));
			meas(np, 16'd20);
			chk(32'(irq), 32'h1);
			rd(8'h44);
			chk(rd_q, 32'h1);
			@(posedge aclk);
			chk(32'(irq), 32'h0);
			rd(8'h50);
			chk(rd_q, exp_res(np, cfg));
			rd(8'h54);
			chk(rd_q, {15'h0, 1'b1, temp_code});
		end
		wr(8'h1c, 32'h40);
		meas(16'd0, 16'd1220);
		rd(8'h4c);
		cnt_prev = rd_q;
		chk(32'(cnt_prev >= 9 && cnt_prev <= 11), 32'h1);
		wr(8'h1c, 32'h08);
		meas(16'd5, 16'd600);
		rd(8'h4c);
		chk(rd_q, cnt_prev);
		rd(8'h54);
		chk(32'(rd_q[16]), 32'h0);
		rd(8'h44);
		wr(8'h40, 32'h71);
		meas(16'd3, 16'd20);
		rd(8'h44);
		chk(rd_q, 32'h0);
		stop_test();
	end
endmodule
